// ===== rtl/sac_top.sv
/*
  Control side of a successive-approximation converter: calibration, start
  handling with the acquisition gap, bit-by-bit decisions on the falling edges
  of the conversion clock, the framing flag, and the serial result output.
  Assumes the comparator result is settled at each conversion clock fall and
  that the pad decodes the three-level select into two levels.
*/
// Notes on behaviour
// [R1]: Select low shuts down, high unipolar, floating bipolar.
// [R2]: Reset low halts; its rise starts calibration.
// [R3]: Start low begins; ignore starts during conversion.
// [R4]: Host drives start in step with conversion clock.
// [R5]: Host ties start to flag or gates it.
// [R6]: Gap reached: begin next fall, flag after.
// [R7]: Gap short: begin fourth fall after end.
// [R8]: Clock high too long needs reset pulse.
// [R9]: Stopped low clock keeps all state intact.
// [R10]: Host keeps conversion clock within rate limits.
// [R11]: Output driven only while select low, MSB first.
// [R12]: Flag stays high while conversion bits appear.
// [R13]: Bits leave on falls; host samples later.
// [R14]: Host reads between conversions with select low.
// [R15]: MSB at select; each pulse advances; then zeros.
// [R16]: Output changes on read clock falling edges.
// [R17]: Host detects completion before reading between conversions.
// [R18]: Host waits about a microsecond before restarting.
// [R19]: Flag rises one cycle after start, falls after end.
// [R20]: Calibration takes about fourteen thousand clock cycles.
// [R21]: Sixteen-bit result decided from most significant bit.
// [R22]: One bit per clock, sixteen flag cycles.
// [R23]: Shutdown ignores starts and releases the output.
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_top #(
  parameter int CAL_CYCLES = `SAC_CAL_CYCLES,
  parameter int WIDTH = `SAC_RESULT_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic convClk,
  input wire logic resetN,
  input wire logic startSampleN,
  input wire logic selDrivenHigh,
  input wire logic selDrivenLow,
  input wire logic csN,
  input wire logic serialClk,
  input wire logic compHigh,
  output logic eoc,
  output logic doutData,
  output logic doutEnable,
  output logic bipolarMode,
  output logic shutdownMode,
  output logic trackInput,
  output logic [WIDTH-1:0] trialCode
);

  localparam int CAL_W = $clog2(CAL_CYCLES + 1);
  localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_CYCLES - 1);

  // Conversion clock domain. All of it works on the falling edge, where bits
  // are decided and shifted out.
  wire [3:0] convSyncIn = {rst, resetN, selDrivenHigh, selDrivenLow};
  wire [3:0] convSyncOut;
  wire rstConv = convSyncOut[3];
  wire resetNConv = convSyncOut[2];
  wire selHighConv = convSyncOut[1];
  wire selLowConv = convSyncOut[0];

  sac_sync #(
    .WIDTH(4),
    .RESET_VALUE(4'h4),
    .FALLING(1'b1)
  ) u_sync_start_sample_n (
    .clk(convClk),
    .rst(1'b0),
    .asyncIn(convSyncIn),
    .syncOut(convSyncOut)
  );

  sac_pkg::sac_state_type state;
  sac_pkg::sac_state_type next_state;
  logic [3:0] bitIdx;
  logic [WIDTH-1:0] result;
  logic [1:0] gap;
  logic pending;
  logic [CAL_W-1:0] calCount;
  logic resetNPrev;
  logic convBit;
  logic resultToggle;

  wire shutdownConv = selLowConv && !selHighConv; // [R1]
  wire resetRise = resetNConv && !resetNPrev; // [R2]
  wire inIdle = state == sac_pkg::SAC_IDLE;
  wire inConv = state == sac_pkg::SAC_START_SAMPLE_N;
  wire inCal = state == sac_pkg::SAC_CAL;
  wire calDone = calCount == CAL_LAST; // [R20]
  wire lastBit = bitIdx == 4'h0;
  wire startLow = !startSampleN;
  // One rule covers both cases: the fourth fall after an end is the one where
  // the gap first reads three, as is any later fall.
  wire gapMet = gap == `SAC_ACQ_GAP; // [R6] [R7]
  wire beginConv = inIdle && (pending || startLow) && gapMet && !shutdownConv; // [R3] [R23]
  wire [WIDTH-1:0] bitMask = WIDTH'(1) << bitIdx;
  // A low comparator keeps the trial bit set.
  wire [WIDTH-1:0] decidedWord = compHigh ? (trialCode & ~bitMask) : trialCode; // [R21]
  wire [WIDTH-1:0] next_trial = decidedWord | (bitMask >> 1);
  wire decidedBit = !compHigh;

  always_comb begin
    next_state = state;
    case (state)
      sac_pkg::SAC_HALT: begin
        if (resetRise) begin
          next_state = sac_pkg::SAC_CAL; // [R2]
        end
      end
      sac_pkg::SAC_CAL: begin
        if (calDone) begin
          next_state = sac_pkg::SAC_IDLE;
        end
      end
      sac_pkg::SAC_IDLE: begin
        if (beginConv) begin
          next_state = sac_pkg::SAC_START_SAMPLE_N;
        end
      end
      sac_pkg::SAC_START_SAMPLE_N: begin
        if (lastBit) begin
          next_state = sac_pkg::SAC_IDLE; // [R22]
        end
      end
      default: begin
        next_state = sac_pkg::SAC_HALT;
      end
    endcase
    if (!resetNConv) begin
      next_state = sac_pkg::SAC_HALT; // [R2]
    end
  end

  // Nothing here times out, so a clock parked low loses no state; only a
  // clock parked high needs the host to recalibrate. [R9]
  always_ff @(negedge convClk) begin
    if (rstConv) begin
      state <= sac_pkg::SAC_CAL;
      resetNPrev <= 1'b1;
      calCount <= '0;
      gap <= 2'h0;
      pending <= 1'b0;
      bitIdx <= `SAC_MSB_INDEX;
      trialCode <= '0;
      result <= `SAC_WORD_RESET;
      convBit <= 1'b0;
      resultToggle <= 1'b0;
      eoc <= 1'b0;
      trackInput <= 1'b0;
    end else begin
      state <= next_state;
      resetNPrev <= resetNConv;
      calCount <= inCal ? calCount + CAL_W'(1) : '0; // [R20]
      gap <= !inIdle ? 2'h0 : (gapMet ? gap : gap + 2'h1);
      pending <= inIdle && !beginConv && !shutdownConv && (pending || startLow); // [R3] [R7]
      eoc <= (inConv || inCal) && resetNConv; // [R19] [R12]
      trackInput <= next_state == sac_pkg::SAC_IDLE;
      if (beginConv) begin
        bitIdx <= `SAC_MSB_INDEX;
        trialCode <= `SAC_MSB_TRIAL; // [R21]
      end else if (inConv) begin
        bitIdx <= bitIdx - 4'h1; // [R22]
        trialCode <= next_trial;
        convBit <= decidedBit; // [R13]
        if (lastBit) begin
          result <= decidedWord;
          resultToggle <= !resultToggle;
        end
      end
    end
  end

  chk_halt_on_low: assert property (@(negedge convClk) disable iff (rstConv) // [R2]
    !resetNConv |=> state == sac_pkg::SAC_HALT && !eoc)
    else $error("Reset low did not halt the converter.");

  chk_cal_on_rise: assert property (@(negedge convClk) disable iff (rstConv) // [R2]
    (state == sac_pkg::SAC_HALT && resetRise) |=> inCal ##1 (eoc || !resetNConv))
    else $error("Reset rise did not start calibration.");

  chk_cal_length: assert property (@(negedge convClk) // [R20]
    disable iff (rstConv || !resetNConv)
    (inCal && calDone) |=> inIdle && !inCal)
    else $error("Calibration did not end at its count.");

  chk_begin_gap: assert property (@(negedge convClk) // [R6]
    disable iff (rstConv || !resetNConv)
    (inIdle && startLow && gapMet && !shutdownConv) |=> inConv ##1 eoc)
    else $error("Start after full gap did not begin at once.");

  chk_short_gap: assert property (@(negedge convClk) // [R7]
    disable iff (rstConv || !resetNConv)
    (inConv && lastBit && !shutdownConv) ##1 (startLow && !shutdownConv)
      |-> ##4 inConv)
    else $error("Early start did not begin on the fourth fall.");

  chk_start_sample_n_span: assert property (@(negedge convClk) // [R22]
    disable iff (rstConv || !resetNConv)
    beginConv |-> ##16 (inConv && lastBit) ##1 (inIdle && eoc) ##1 !eoc)
    else $error("Conversion did not span sixteen cycles.");

  chk_start_ignored: assert property (@(negedge convClk) // [R3]
    disable iff (rstConv || !resetNConv)
    (inConv && !lastBit) |=> inConv && !pending)
    else $error("Start strobe disturbed a running conversion.");

  chk_msb_trial: assert property (@(negedge convClk) // [R21]
    disable iff (rstConv || !resetNConv)
    beginConv |=> trialCode == `SAC_MSB_TRIAL && bitIdx == `SAC_MSB_INDEX)
    else $error("Conversion did not start from the top bit.");

  chk_bit_out: assert property (@(negedge convClk) // [R13]
    disable iff (rstConv || !resetNConv)
    inConv |=> convBit == !$past(compHigh))
    else $error("Decided bit was not shifted out.");

  chk_shutdown_idle: assert property (@(negedge convClk) // [R23]
    disable iff (rstConv || !resetNConv)
    (inIdle && shutdownConv) |=> inIdle && !pending)
    else $error("Shutdown did not ignore a start.");

  chk_track_start_sample_n: assert property (@(negedge convClk) // [R22]
    disable iff (rstConv || !resetNConv)
    (inConv && !lastBit) |=> !trackInput)
    else $error("Input tracked during a conversion.");

  chk_track_after: assert property (@(negedge convClk) // [R6]
    disable iff (rstConv || !resetNConv)
    (inConv && lastBit) |=> trackInput)
    else $error("Input not tracked after a conversion.");

  // System clock domain. The framing flag and the bit are levels; the word is
  // taken on a toggle, and it stays still for at least sixteen conversion
  // cycles, far longer than the two-edge crossing.
  // That margin only exists while the conversion clock runs less than eight times as fast as clk.
  wire [6:0] sysSyncIn = {eoc, convBit, resultToggle, csN, serialClk,
    selDrivenHigh, selDrivenLow};
  wire [6:0] sysSyncOut;
  wire eocSys = sysSyncOut[6];
  wire convBitSys = sysSyncOut[5];
  wire toggleSys = sysSyncOut[4];
  wire csNSys = sysSyncOut[3];
  wire sclkSys = sysSyncOut[2];
  wire selHighSys = sysSyncOut[1];
  wire selLowSys = sysSyncOut[0];

  sac_sync #(
    .WIDTH(7),
    .RESET_VALUE(7'h08),
    .FALLING(1'b0)
  ) u_sync_sys (
    .clk(clk),
    .rst(rst),
    .asyncIn(sysSyncIn),
    .syncOut(sysSyncOut)
  );

  logic togglePrev;
  logic [WIDTH-1:0] resultWord;

  wire newResult = toggleSys != togglePrev;

  always_ff @(posedge clk) begin
    if (rst) begin
      togglePrev <= 1'b0;
      resultWord <= `SAC_WORD_RESET;
      bipolarMode <= 1'b0;
      shutdownMode <= 1'b0;
    end else begin
      togglePrev <= toggleSys;
      if (newResult) begin
        resultWord <= result;
      end
      bipolarMode <= !selHighSys && !selLowSys; // [R1]
      shutdownMode <= selLowSys && !selHighSys; // [R1]
    end
  end

  sac_serial_readout #(
    .WIDTH(WIDTH)
  ) u_readout (
    .clk(clk),
    .rst(rst),
    .csN(csNSys),
    .serialClk(sclkSys),
    .framing(eocSys),
    .convBit(convBitSys),
    .shutdown(shutdownMode),
    .resultWord(resultWord),
    .doutData(doutData),
    .doutEnable(doutEnable)
  );

  chk_range_decode: assert property (@(posedge clk) disable iff (rst) // [R1]
    $past(selHighSys) |-> !bipolarMode && !shutdownMode)
    else $error("Select driven high did not give unipolar range.");

endmodule

// ===== rtl/sac_defines.svh
/*
  Constants of the converter control block: result width, acquisition gap,
  calibration length and reset values. Assumes inclusion by bare name.
*/
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

`define SAC_RESULT_BITS 16
`define SAC_MSB_INDEX 4'hf
`define SAC_MSB_TRIAL 16'h8000
`define SAC_ACQ_GAP 2'h3
`define SAC_CAL_CYCLES 14000
`define SAC_SYNC_STAGES 2
`define SAC_WORD_RESET 16'h0000
`define SAC_CS_IDLE 1'b1

`endif

// ===== rtl/sac_pkg.sv
/*
  Types of the converter control block. Assumes nothing of its surroundings.
*/
package sac_pkg;

  // Gray order along halt, calibrate, idle, convert, back to idle.
  typedef enum logic [1:0] {
    SAC_HALT = 2'h0,
    SAC_CAL = 2'h1,
    SAC_IDLE = 2'h3,
    SAC_START_SAMPLE_N = 2'h2
  } sac_state_type;

endpackage

// ===== rtl/sac_sync.sv
/*
  Two-flop synchroniser for a group of levels, on either edge of its clock.
  Assumes each bit is a level that stays put for more than two clock edges.
*/
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter bit FALLING = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // The first stage is read by the second stage only.
  logic [WIDTH-1:0] stage1;

  generate
    if (FALLING) begin : g_fall
      always_ff @(negedge clk) begin
        if (rst) begin
          stage1 <= RESET_VALUE;
          syncOut <= RESET_VALUE;
        end else begin
          stage1 <= asyncIn;
          syncOut <= stage1;
        end
      end
    end else begin : g_rise
      always_ff @(posedge clk) begin
        if (rst) begin
          stage1 <= RESET_VALUE;
          syncOut <= RESET_VALUE;
        end else begin
          stage1 <= asyncIn;
          syncOut <= stage1;
        end
      end
    end
  endgenerate

endmodule

// ===== rtl/sac_serial_readout.sv
/*
  Serial result output on the system clock: passes conversion bits through
  while the framing flag is high, and shifts the stored word out on the serial
  read clock between conversions. Assumes all inputs are already synchronised.
*/
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_serial_readout #(
  parameter int WIDTH = `SAC_RESULT_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic serialClk,
  input wire logic framing,
  input wire logic convBit,
  input wire logic shutdown,
  input wire logic [WIDTH-1:0] resultWord,
  output logic doutData,
  output logic doutEnable
);

  logic csPrev;
  logic sclkPrev;
  logic [WIDTH-1:0] shiftReg;

  wire csFall = csPrev && !csN;
  wire sclkFall = sclkPrev && !serialClk;
  wire shiftNow = sclkFall && !csN && !csFall;
  // Zeros follow the last bit, as the word empties from the top.
  wire [WIDTH-1:0] next_shift = csFall ? resultWord :
    (shiftNow ? {shiftReg[WIDTH-2:0], 1'b0} : shiftReg); // [R15] [R16]

  always_ff @(posedge clk) begin
    if (rst) begin
      csPrev <= `SAC_CS_IDLE;
      sclkPrev <= 1'b0;
      shiftReg <= '0;
      doutData <= 1'b0;
      doutEnable <= 1'b0;
    end else begin
      csPrev <= csN;
      sclkPrev <= serialClk;
      shiftReg <= next_shift;
      doutData <= framing ? convBit : next_shift[WIDTH-1]; // [R13] [R15]
      doutEnable <= !csN && !shutdown; // [R11] [R23]
    end
  end

  chk_output_enable: assert property (@(posedge clk) disable iff (rst) // [R11]
    doutEnable |-> !$past(csN) && !$past(shutdown))
    else $error("Serial output driven without chip select.");

  chk_msb_on_select: assert property (@(posedge clk) disable iff (rst) // [R15]
    (csFall && !framing) |=> doutData == $past(resultWord[WIDTH-1]))
    else $error("Select did not present the top bit.");

  chk_shift_one_bit: assert property (@(posedge clk) disable iff (rst) // [R16]
    (shiftNow && !framing) |=> doutData == $past(shiftReg[WIDTH-2]))
    else $error("Serial clock fall did not advance one bit.");

endmodule

// ===== verification/sac_host_model.sv
/*
  Behavioural host around the converter: conversion clock, start strobe and
  a comparator that steers the trial code towards a held input code.
  Assumes the bench drives its controls off the system clock.
*/
`timescale 1ns/1ps
module sac_host_model (
  input wire logic runClk,
  input wire logic contMode,
  input wire logic startReq,
  input wire logic pauseMid,
  input wire logic eoc,
  input wire logic [15:0] target,
  input wire logic [15:0] trialCode,
  output logic convClk,
  output logic startSampleN,
  output logic compHigh
);
  logic lastReq;
  int midCnt;

  // The comparator reads low while the held input is at or above the trial code.
  assign compHigh = trialCode > target;

  initial begin
    convClk = 1'h0;
    startSampleN = 1'h1;
    lastReq = 1'h0;
    midCnt = 0;
    #0.7;
    forever begin
      #3;
      if (convClk && midCnt == 8) begin
        // Parking mid conversion only ever in the low state keeps state safe.
        convClk = 1'h0;
        #2000;
      end else if (runClk || convClk) begin
        // The rate is scaled up along with the shortened calibration.
        convClk = ~convClk;
      end
    end
  end

  // Start changes on rising edges so it is settled at every falling edge.
  always @(posedge convClk) begin
    startSampleN <= !(contMode || startReq != lastReq);
    lastReq <= startReq;
  end

  always @(negedge convClk) begin
    midCnt <= (pauseMid && eoc) ? midCnt + 1 : 0;
  end
endmodule

// ===== verification/test_sar_adc_control_and_serial_readout.sv
/*
  Self-checking bench for the converter control block with a host model.
  Assumes a shortened calibration and a fast, unrelated conversion clock.
*/
`timescale 1ns/1ps
module test_sar_adc_control_and_serial_readout;
  localparam int CAL = 20;
  logic clk, rst, resetN, selDrivenHigh, selDrivenLow, csN, serialClk;
  logic runClk, contMode, startReq, pauseMid, eocPrev, startPrev;
  logic convClk, startSampleN, compHigh, eoc, doutData, doutEnable;
  logic bipolarMode, shutdownMode, trackInput;
  logic [15:0] target, trialCode;
  int errorCnt, samplesChecked, fallCnt, riseAt, fellAt, gapAt, highLen, ends, startFall, n;
  logic [15:0] codes [3] = '{16'hffff, 16'h0000, 16'ha5c3};

  sac_top #(.CAL_CYCLES(CAL)) uut (.clk(clk), .rst(rst), .convClk(convClk), .resetN(resetN),
    .startSampleN(startSampleN), .selDrivenHigh(selDrivenHigh), .selDrivenLow(selDrivenLow),
    .csN(csN), .serialClk(serialClk), .compHigh(compHigh), .eoc(eoc), .doutData(doutData),
    .doutEnable(doutEnable), .bipolarMode(bipolarMode), .shutdownMode(shutdownMode),
    .trackInput(trackInput), .trialCode(trialCode));

  sac_host_model host (.runClk(runClk), .contMode(contMode), .startReq(startReq),
    .pauseMid(pauseMid), .eoc(eoc), .target(target), .trialCode(trialCode),
    .convClk(convClk), .startSampleN(startSampleN), .compHigh(compHigh));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Counting conversion clock falls lets flag timing be judged in whole cycles.
  always @(negedge convClk) begin
    fallCnt++;
    if (!startSampleN && startPrev) startFall = fallCnt;
    startPrev = startSampleN;
  end

  always @(posedge convClk) begin
    if (eoc === 1'h1 && eocPrev === 1'h0) begin
      riseAt = fallCnt;
      gapAt = fallCnt - fellAt;
    end
    if (eoc === 1'h0 && eocPrev === 1'h1) begin
      fellAt = fallCnt;
      highLen = fellAt - riseAt;
      ends++;
    end
    eocPrev = eoc;
  end

  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  task look;
    @(negedge clk);
  endtask

  task chk_bit(input string name, input logic e, input logic g);
    samplesChecked++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task chk_num(input string name, input int e, input int g);
    samplesChecked++;
    if (g != e) begin
      errorCnt++;
      $display("MISMATCH %s expected %0d seen %0d", name, e, g);
    end
  endtask

  // Completion is found by counting falls of the framing flag, under a bound.
  task wait_end(input int want);
    int k;
    k = 0;
    while (ends < want && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (ends < want) chk_num("conversion ends", want, ends);
  endtask

  task convert(input logic [15:0] code);
    tick(10);
    target <= code;
    startReq <= !startReq;
    wait_end(ends + 1);
    look;
  endtask

  function automatic logic word_bit(input logic [15:0] w, input int k);
    return (k < 16) ? w[15 - k] : 1'h0;
  endfunction

  task read_word(input logic [15:0] w);
    tick(1);
    csN <= 1'h0;
    tick(4);
    look;
    chk_bit("dout enable", 1'h1, doutEnable);
    chk_bit("dout msb", w[15], doutData);
    for (int i = 1; i <= 17; i++) begin
      tick(1);
      serialClk <= 1'h1;
      tick(4);
      look;
      chk_bit("dout on rise", word_bit(w, i - 1), doutData);
      tick(1);
      serialClk <= 1'h0;
      tick(4);
      look;
      chk_bit("dout bit", word_bit(w, i), doutData);
    end
    tick(1);
    csN <= 1'h1;
    tick(4);
    look;
    chk_bit("dout release", 1'h0, doutEnable);
  endtask

  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    errorCnt++;
    tally_and_finish();
  end

  initial begin
    {rst, resetN, runClk, csN} = 4'hf;
    {selDrivenHigh, selDrivenLow, serialClk, contMode, startReq, pauseMid} = 6'h0;
    {eocPrev, startPrev} = 2'h1;
    target = 16'h0000;
    tick(3);
    rst <= 1'h0;
    wait_end(1);
    look;
    chk_num("calibration span", 1, int'(highLen >= CAL - 2 && highLen <= CAL + 2));
    chk_bit("bipolar floating", 1'h1, bipolarMode);
    chk_bit("shutdown floating", 1'h0, shutdownMode);
    chk_bit("dout idle", 1'h0, doutEnable);
    $display("Test reset done");
    foreach (codes[i]) begin
      convert(codes[i]);
      chk_num("start to flag", 1, riseAt - startFall);
      chk_num("flag length", 16, highLen);
      chk_bit("track after end", 1'h1, trackInput);
      read_word(codes[i]);
    end
    $display("Test single conversions done");
    tick(1);
    target <= 16'h3c5a;
    contMode <= 1'h1;
    wait_end(ends + 2);
    contMode <= 1'h0;
    look;
    chk_num("gap to next flag", 4, gapAt);
    chk_num("flag length held start", 16, highLen);
    tick(3);
    read_word(16'h3c5a);
    $display("Test back to back done");
    tick(1);
    selDrivenLow <= 1'h1;
    tick(4);
    look;
    chk_bit("shutdown low", 1'h1, shutdownMode);
    chk_bit("bipolar low", 1'h0, bipolarMode);
    n = ends;
    tick(1);
    startReq <= !startReq;
    csN <= 1'h0;
    tick(4);
    look;
    chk_num("ends in shutdown", n, ends);
    chk_bit("dout in shutdown", 1'h0, doutEnable);
    tick(1);
    csN <= 1'h1;
    selDrivenLow <= 1'h0;
    selDrivenHigh <= 1'h1;
    tick(4);
    look;
    chk_bit("bipolar high", 1'h0, bipolarMode);
    chk_bit("shutdown high", 1'h0, shutdownMode);
    convert(16'h8001);
    read_word(16'h8001);
    $display("Test shutdown done");
    tick(1);
    resetN <= 1'h0;
    tick(4);
    look;
    chk_bit("flag in halt", 1'h0, eoc);
    chk_bit("track in halt", 1'h0, trackInput);
    n = ends;
    tick(1);
    startReq <= !startReq;
    tick(4);
    look;
    chk_num("ends in halt", n, ends);
    tick(1);
    resetN <= 1'h1;
    wait_end(n + 1);
    look;
    chk_num("recalibration span", 1, int'(highLen >= CAL - 2 && highLen <= CAL + 2));
    $display("Test halt done");
    tick(1);
    pauseMid <= 1'h1;
    convert(16'h7ffe);
    chk_num("flag length paused", 16, highLen);
    read_word(16'h7ffe);
    $display("Test stopped clock done");
    tally_and_finish();
  end
endmodule
